// [rtl/lbt_pkg.sv]
// Contract
// - Eight independent bits each way, three wires.
// - Card input inverted before reaching backplane.
// - Backplane or feedback inverted onto card output.
// - Each direction has its own mode pair.
// - 00 buffer, 01 flip-flop, 1x latch.
// - Buffer passes input without clocking; the code registers it and it arrives three pclk edges late.
// - Flip-flop captures on rising direction clock.
// - Latch transparent while gate high, else holds.
// - Feedback low: inbound element reads backplane.
// - Feedback high: inbound reads outbound element output.
// - Card enable low floats card output bus.
// - Card enable high drives card output bus; the code also needs the CTRL isolate bit clear.
// - Backplane idle if enable low or enable_n high.
// - Backplane drives only when both enables agree.
// - Elements keep working while outputs disabled.
// - Both enabled, no feedback: transparent both ways; the code also needs the CTRL isolate bit clear.
package lbt_pkg;

  localparam int unsigned LBT_DW = 8;
  localparam int unsigned LBT_AW = 12;

  localparam logic [LBT_AW-1:0] LBT_CTRL_OFS   = 12'h000;
  localparam logic [LBT_AW-1:0] LBT_STATUS_OFS = 12'h004;
  localparam logic [LBT_AW-1:0] LBT_PINS_OFS   = 12'h008;

  localparam logic [31:0] LBT_CTRL_RESET  = 32'h0000_0000;
  localparam int unsigned LBT_CTRL_ISO_BIT = 0;

  localparam int unsigned LBT_ST_OUTQ_LSB  = 0;
  localparam int unsigned LBT_ST_INQ_LSB   = 8;
  localparam int unsigned LBT_ST_CARD_BIT  = 16;
  localparam int unsigned LBT_ST_BP_BIT    = 17;
  localparam int unsigned LBT_ST_SPEED_BIT = 18;
  localparam int unsigned LBT_ST_FB_BIT    = 19;
  localparam int unsigned LBT_ST_OMODE_LSB = 20;
  localparam int unsigned LBT_ST_IMODE_LSB = 22;

  localparam int unsigned LBT_PN_CARD_LSB = 0;
  localparam int unsigned LBT_PN_BP_LSB   = 8;

  typedef enum logic [1:0] {
    LBT_BUF = 2'h0,
    LBT_FF  = 2'h1,
    LBT_LAT = 2'h3
  } lbt_mode_t;

  typedef struct packed {
    logic [LBT_DW-1:0] card_input_bus;
    logic [LBT_DW-1:0] backplane_rx;
    logic              card_output_enable;
    logic              backplane_drive_enable;
    logic              backplane_drive_enable_n;
    logic              inbound_sel_hi;
    logic              inbound_sel_lo;
    logic              outbound_sel_hi;
    logic              outbound_sel_lo;
    logic              outbound_clock_or_gate;
    logic              inbound_clock_or_gate;
    logic              feedback_select;
    logic              edge_speed_select;
  } lbt_pins_t;

  typedef struct packed {
    logic [LBT_DW-1:0] held;
    logic              gate_prev;
  } lbt_elem_state_t;

  typedef struct packed {
    lbt_pins_t         sync1;
    lbt_pins_t         sync2;
    logic              isolate;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [LBT_DW-1:0] card_out;
    logic              card_oe;
    logic [LBT_DW-1:0] bp_do;
    logic [LBT_DW-1:0] bp_oe;
  } lbt_top_state_t;

  function automatic lbt_mode_t lbt_decode_mode(input logic hi, input logic lo);
    if (hi) begin
      return LBT_LAT;
    end else if (lo) begin
      return LBT_FF;
    end else begin
      return LBT_BUF;
    end
  endfunction

endpackage

// [rtl/lbt_elem.sv]
`timescale 1ns/100ps
module lbt_elem (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire lbt_pkg::lbt_mode_t        mode,
  input  wire logic                      gate,
  input  wire logic [lbt_pkg::LBT_DW-1:0] din,
  output logic      [lbt_pkg::LBT_DW-1:0] q
);
  import lbt_pkg::*;

  lbt_elem_state_t r;
  lbt_elem_state_t nxt;

  // Storage runs in flip-flop and latch modes regardless of output enables.
  always_comb begin
    nxt           = r;
    nxt.gate_prev = gate;
    case (mode)
      LBT_FF: begin
        if (gate && !r.gate_prev) begin
          nxt.held = din;
        end
      end
      LBT_LAT: begin
        if (gate) begin
          nxt.held = din;
        end
      end
      default: begin
        nxt.held = r.held;
      end
    endcase
  end

  always_comb begin
    case (mode)
      LBT_BUF: q = din;
      LBT_FF:  q = r.held;
      LBT_LAT: q = gate ? din : r.held;
      default: q = din;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

endmodule

// [rtl/lbt_xcvr.sv]
`timescale 1ns/100ps
module lbt_xcvr (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [lbt_pkg::LBT_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire lbt_pkg::lbt_pins_t         pins,
  output logic      [lbt_pkg::LBT_DW-1:0] card_output_bus,
  output logic                            card_output_oe,
  output logic      [lbt_pkg::LBT_DW-1:0] backplane_do,
  output logic      [lbt_pkg::LBT_DW-1:0] backplane_oe
);
  import lbt_pkg::*;

  lbt_top_state_t    r;
  lbt_top_state_t    nxt;
  lbt_mode_t         out_mode;
  lbt_mode_t         in_mode;
  logic [LBT_DW-1:0] out_q;
  logic [LBT_DW-1:0] in_q;
  logic [LBT_DW-1:0] in_din;
  logic              card_active;
  logic              bp_active;
  logic [31:0]       status_word;
  logic [31:0]       pins_word;

  // Two separate mode pairs, one element per direction.
  assign out_mode = lbt_decode_mode(r.sync2.outbound_sel_hi, r.sync2.outbound_sel_lo);
  assign in_mode  = lbt_decode_mode(r.sync2.inbound_sel_hi, r.sync2.inbound_sel_lo);

  // The feedback tap is taken before the outbound inversion.
  assign in_din = r.sync2.feedback_select ? out_q : r.sync2.backplane_rx;

  assign card_active = r.sync2.card_output_enable & ~r.isolate;
  assign bp_active   = r.sync2.backplane_drive_enable & ~r.sync2.backplane_drive_enable_n
                       & ~r.isolate;

  lbt_elem u_outbound (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (out_mode),
    .gate    (r.sync2.outbound_clock_or_gate),
    .din     (r.sync2.card_input_bus),
    .q       (out_q)
  );

  lbt_elem u_inbound (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (in_mode),
    .gate    (r.sync2.inbound_clock_or_gate),
    .din     (in_din),
    .q       (in_q)
  );

  always_comb begin
    status_word                                 = '0;
    status_word[LBT_ST_OUTQ_LSB +: LBT_DW]      = out_q;
    status_word[LBT_ST_INQ_LSB +: LBT_DW]       = in_q;
    status_word[LBT_ST_CARD_BIT]                = card_active;
    status_word[LBT_ST_BP_BIT]                  = bp_active;
    status_word[LBT_ST_SPEED_BIT]               = r.sync2.edge_speed_select;
    status_word[LBT_ST_FB_BIT]                  = r.sync2.feedback_select;
    status_word[LBT_ST_OMODE_LSB +: 2]          = out_mode;
    status_word[LBT_ST_IMODE_LSB +: 2]          = in_mode;
    pins_word                                   = '0;
    pins_word[LBT_PN_CARD_LSB +: LBT_DW]        = r.sync2.card_input_bus;
    pins_word[LBT_PN_BP_LSB +: LBT_DW]          = r.sync2.backplane_rx;
  end

  // Pins pass two flops before any logic, so buffer-mode paths lag the pins by three cycles.
  always_comb begin
    nxt       = r;
    nxt.sync1 = pins;
    nxt.sync2 = r.sync1;

    nxt.card_out = ~in_q;
    nxt.card_oe  = card_active;
    nxt.bp_do    = '0;
    // Open-drain: pull low where the inverted outbound bit is low.
    nxt.bp_oe    = bp_active ? out_q : '0;

    nxt.pready  = psel & ~penable;
    nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        LBT_CTRL_OFS: begin
          nxt.prdata                   = '0;
          nxt.prdata[LBT_CTRL_ISO_BIT] = r.isolate;
        end
        LBT_STATUS_OFS: nxt.prdata = status_word;
        LBT_PINS_OFS:   nxt.prdata = pins_word;
        default: begin
          nxt.prdata  = '0;
          nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && r.pready && pwrite && paddr == LBT_CTRL_OFS) begin
      nxt.isolate = pwdata[LBT_CTRL_ISO_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.isolate <= LBT_CTRL_RESET[LBT_CTRL_ISO_BIT];
    end else begin
      r <= nxt;
    end
  end

  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign card_output_bus = r.card_out;
  assign card_output_oe  = r.card_oe;
  assign backplane_do    = r.bp_do;
  assign backplane_oe    = r.bp_oe;

endmodule

// [verif/lbt_backplane.sv]
`timescale 1ns/100ps
module lbt_backplane (
  input  wire logic [lbt_pkg::LBT_DW-1:0] backplane_oe,
  input  wire logic [lbt_pkg::LBT_DW-1:0] other_pull,
  output logic      [lbt_pkg::LBT_DW-1:0] line
);
  // The pull-up makes a released line read high, so no stale level survives a release.
  assign line = ~(backplane_oe | other_pull);
endmodule

// [verif/lbt_xcvr_sva.sv]
`timescale 1ns/100ps
module lbt_xcvr_sva
  import lbt_pkg::*;
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic [lbt_pkg::LBT_AW-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire lbt_pkg::lbt_pins_t         pins,
  input wire logic [lbt_pkg::LBT_DW-1:0] card_output_bus,
  input wire logic                       card_output_oe,
  input wire logic [lbt_pkg::LBT_DW-1:0] backplane_do,
  input wire logic [lbt_pkg::LBT_DW-1:0] backplane_oe
);
  // Pins reach the outputs after three edges, so the checks compare with a delayed copy.
  lbt_pins_t  d1, d2, d3;
  logic       bp_on, ob_buf, ib_buf;
  logic [1:0] warm;
  logic       iso_m, iso_d;
  always_ff @(posedge pclk) begin
    d1 <= pins;
    d2 <= d1;
    d3 <= d2;
  end
  // Outputs come from zeroed synchronisers for a few edges after reset, so data checks wait for warm.
  // The isolate bit is rebuilt from bus writes and delayed once, as the outputs see it one edge late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm  <= 2'h0;
      iso_m <= LBT_CTRL_RESET[LBT_CTRL_ISO_BIT];
      iso_d <= LBT_CTRL_RESET[LBT_CTRL_ISO_BIT];
    end else begin
      if (warm != 2'h3) begin
        warm <= warm + 2'h1;
      end
      if (psel && penable && pready && pwrite && paddr == LBT_CTRL_OFS) begin
        iso_m <= pwdata[LBT_CTRL_ISO_BIT];
      end
      iso_d <= iso_m;
    end
  end
  assign bp_on  = d3.backplane_drive_enable && !d3.backplane_drive_enable_n;
  assign ob_buf = !d3.outbound_sel_hi && !d3.outbound_sel_lo;
  assign ib_buf = !d3.inbound_sel_hi && !d3.inbound_sel_lo;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_card_float: assert property ((!d3.card_output_enable || iso_d) |-> !card_output_oe)
    else $error("card bus driven");
  a_card_active: assert property (warm == 2'h3 && d3.card_output_enable && !iso_d |-> card_output_oe)
    else $error("card bus not driven");
  a_bp_idle: assert property ((!bp_on || iso_d) |-> backplane_oe == 8'h00) else $error("backplane driven");
  a_bp_open_drain: assert property (backplane_do == 8'h00) else $error("backplane driven high");
  a_bp_inverted: assert property (warm == 2'h3 && bp_on && ob_buf && !iso_d |-> backplane_oe == d3.card_input_bus)
    else $error("backplane data wrong");
  a_card_inverted: assert property (warm == 2'h3 && ib_buf && !d3.feedback_select
    |-> card_output_bus == ~d3.backplane_rx) else $error("card data wrong");
  a_card_feedback: assert property (warm == 2'h3 && ib_buf && ob_buf && d3.feedback_select
    |-> card_output_bus == ~d3.card_input_bus) else $error("feedback data wrong");
  a_ready_next: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_unmapped: assert property (psel && !penable && paddr > LBT_PINS_OFS |=> pslverr && pready)
    else $error("no error");
endmodule
bind lbt_xcvr lbt_xcvr_sva u_sva (.*);

// [verif/lbt_xcvr_test.sv]
`timescale 1ns/100ps
module lbt_xcvr_test;
  import lbt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, coe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  cob, bdo, boe, other_pull, line;
  logic        er;
  lbt_pins_t   pn, v, pins_w;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  always_comb begin
    pins_w = pn;
    pins_w.backplane_rx = line;
  end
  lbt_xcvr u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins_w),
    .card_output_bus(cob), .card_output_oe(coe), .backplane_do(bdo), .backplane_oe(boe));
  lbt_backplane u_bp (.backplane_oe(boe), .other_pull(other_pull), .line(line));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task setp;
    @(posedge pclk);
    pn <= v;
    // The card output can depend on the backplane line, which itself follows the card input.
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    v = '0;
    v.backplane_drive_enable_n = 1'b1;
    pn = v;
    other_pull = 8'h00;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LBT_CTRL_OFS, 32'h0);
    chk(rd, LBT_CTRL_RESET);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(er), 32'h1);
    $display("test registers done");
    {v.card_output_enable, v.backplane_drive_enable, v.backplane_drive_enable_n} = 3'b110;
    v.card_input_bus = 8'hA5;
    setp;
    chk(32'(boe), 32'hA5);
    chk(32'(cob), 32'hA5);
    chk(32'(coe), 32'h1);
    other_pull <= 8'h3C;
    v.card_input_bus = 8'h00;
    setp;
    chk(32'(cob), 32'h3C);
    v.feedback_select = 1'b1;
    v.card_input_bus = 8'h5A;
    setp;
    chk(32'(cob), 32'hA5);
    $display("test transparent done");
    {v.card_output_enable, v.backplane_drive_enable_n, v.outbound_sel_lo} = 3'b011;
    v.card_input_bus = 8'h11;
    setp;
    chk(32'(coe), 32'h0);
    chk(32'(boe), 32'h0);
    v.outbound_clock_or_gate = 1'b1;
    setp;
    v.outbound_clock_or_gate = 1'b0;
    v.card_input_bus = 8'h22;
    setp;
    apb(1'b0, LBT_STATUS_OFS, 32'h0);
    chk(32'(rd[LBT_ST_OUTQ_LSB +: 8]), 32'h11);
    chk(32'(rd[LBT_ST_OMODE_LSB +: 2]), 32'h1);
    {v.outbound_sel_hi, v.outbound_clock_or_gate} = 2'b11;
    v.card_input_bus = 8'h33;
    setp;
    v.outbound_clock_or_gate = 1'b0;
    setp;
    v.card_input_bus = 8'h44;
    setp;
    apb(1'b0, LBT_STATUS_OFS, 32'h0);
    chk(32'(rd[LBT_ST_OUTQ_LSB +: 8]), 32'h33);
    chk(32'(rd[LBT_ST_OMODE_LSB +: 2]), 32'h3);
    $display("test elements done");
    v.card_output_enable = 1'b1;
    setp;
    chk(32'(cob), 32'hCC);
    apb(1'b1, LBT_CTRL_OFS, 32'h1);
    repeat (4) @(posedge pclk);
    chk(32'(coe), 32'h0);
    apb(1'b1, LBT_CTRL_OFS, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(coe), 32'h1);
    $display("test isolate done");
    {v.feedback_select, v.inbound_sel_lo} = 2'b01;
    setp;
    chk(32'(cob), 32'hFF);
    {v.inbound_clock_or_gate, v.edge_speed_select} = 2'b11;
    setp;
    chk(32'(cob), 32'h3C);
    v.inbound_clock_or_gate = 1'b0;
    other_pull <= 8'hF0;
    setp;
    chk(32'(cob), 32'h3C);
    apb(1'b0, LBT_STATUS_OFS, 32'h0);
    chk(32'(rd[LBT_ST_INQ_LSB +: 8]), 32'hC3);
    chk(32'(rd[LBT_ST_IMODE_LSB +: 2]), 32'h1);
    chk(32'(rd[LBT_ST_CARD_BIT]), 32'h1);
    chk(32'(rd[LBT_ST_BP_BIT]), 32'h0);
    chk(32'(rd[LBT_ST_SPEED_BIT]), 32'h1);
    apb(1'b0, LBT_PINS_OFS, 32'h0);
    chk(32'(rd[LBT_PN_BP_LSB +: 8]), 32'h0F);
    chk(32'(rd[LBT_PN_CARD_LSB +: 8]), 32'h44);
    {v.inbound_sel_hi, v.inbound_clock_or_gate} = 2'b11;
    setp;
    chk(32'(cob), 32'hF0);
    $display("test inbound done");
    close_out;
  end
endmodule
